//--- trig_edge_detect.sv
`timescale 1ns/1ns
// selected-edge detector for the isolated trigger input
module trig_edge_detect
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  // control
  input  wire logic fall_sel,
  // pin and result
  input  wire logic pin,
  output logic      edge_pulse
);

  logic prev_ff;

  // ----------------------------------------------------------------------
  // history
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      prev_ff <= 1'b0;
    else if (ce)
      prev_ff <= pin;
  end

  assign edge_pulse = ce & (fall_sel ? (prev_ff & ~pin) : (~prev_ff & pin));

endmodule : trig_edge_detect

//--- trig_flash_defines.svh
`ifndef TRIG_FLASH_DEFINES_SVH
`define TRIG_FLASH_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (word addresses on the plain register port)
// ----------------------------------------------------------------------
`define REG_CTRL_OFS        4'h0
`define REG_TRIG_DELAY_OFS  4'h1
`define REG_FLASH_DELAY_OFS 4'h2
`define REG_FLASH_DUR_OFS   4'h3
`define REG_EXPOSURE_OFS    4'h4
`define REG_LATENCY_OFS     4'h5
`define REG_READOUT_OFS     4'h6
`define REG_STATUS_OFS      4'h7

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTRL_TRIG_MODE_BIT  0
`define CTRL_FALL_EDGE_BIT  1
`define CTRL_FLASH_EN_BIT   2
`define CTRL_FLASH_STAT_BIT 3
`define CTRL_STAT_LEVEL_BIT 4
`define CTRL_RUN_BIT        5
`define CTRL_SW_TRIG_BIT    6
`define CTRL_WIDTH          7

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define STAT_BUSY_BIT       0
`define STAT_FLASH_BIT      1
`define STAT_ISO_IN_BIT     2
`define STAT_PHASE_LSB      3
`define STAT_GPIO_LSB       8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CTRL_RST            7'h00
`define TIME_RST            32'h0000_0000
`define EXPOSURE_RST        32'h0000_0064
`define LATENCY_RST         32'h0000_0010
`define READOUT_RST         32'h0000_0100

// ----------------------------------------------------------------------
// timing: extra flash time in automatic mode, in ns, and in cycles
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       10
`define AUTO_TAIL_NS        40
`define AUTO_TAIL_CYC       ((`AUTO_TAIL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROLLING_EXTRA_CYC   8

`endif

//--- trig_flash_pkg.sv
package trig_flash_pkg;

  // capture sequence phases
  typedef enum logic [2:0]
  {
    PH_IDLE,
    PH_TRIG_DELAY,
    PH_LATENCY,
    PH_EXPOSE,
    PH_READOUT
  } phase_type;

  // register port request
  typedef struct packed
  {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  // timing set latched at the start of each capture
  typedef struct packed
  {
    logic [31:0] trig_delay;
    logic [31:0] flash_delay;
    logic [31:0] flash_dur;
    logic [31:0] exposure;
    logic [31:0] latency;
    logic [31:0] readout;
  } timing_type;

endpackage : trig_flash_pkg

//--- trig_flash_props.sv
`timescale 1ns/1ns
`include "trig_flash_defines.svh"
// ----------------------------------------------------------------------
// port level checks for the trigger and flash sequencer
// ----------------------------------------------------------------------
module trig_flash_props
#(
  parameter int GPIO_W = 4
)
(
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic                        ce,
  // host link and register port
  input wire logic                        host_present,
  input wire trig_flash_pkg::reg_req_type reg_req,
  input wire logic [31:0]                 rd_data,
  // pins and sensor side
  input wire logic                        iso_in,
  input wire logic [GPIO_W-1:0]           gpio_in,
  input wire logic                        flash_out,
  input wire logic                        rolling_shutter,
  input wire logic                        expose,
  input wire logic                        frame_done
);
  logic [5:0] csh_ff;  // control shadow; the sw trigger bit self clears, so it is left out

  // shadow of the control word, cleared with the host link like the real one
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      csh_ff <= 6'h00;
    else if (ce)
    begin
      if (!host_present)
        csh_ff <= 6'h00;
      else if (reg_req.wr && reg_req.addr == `REG_CTRL_OFS)
        csh_ff <= reg_req.wdata[5:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_RD_ZERO_IDLE:
    assert property ($past(ce) && !$past(reg_req.rd) |-> rd_data == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_HOST_LOSS_OFF:
    assert property ((!host_present && ce)[*2] |-> !flash_out && !expose)
    else $error("flash or exposure active without host link");
  AST_EXPOSE_ENDS:
    assert property (disable iff (!rst_b || !host_present) $rose(expose) |-> ##[1:1000] !expose)
    else $error("exposure did not end");
  AST_DONE_AFTER_EXPOSE:
    assert property (disable iff (!rst_b || !host_present)
      $fell(expose) |-> ##[0:1000] frame_done)
    else $error("no frame done after exposure");
  AST_DONE_QUIET:
    assert property (frame_done |-> !expose ##1 (!expose && !frame_done))
    else $error("frame done overlaps exposure or is longer than one cycle");
  AST_STATIC_LEVEL:
    assert property ((ce && csh_ff[2] && csh_ff[3] && !csh_ff[5] && $stable(csh_ff))[*3]
      |-> flash_out == csh_ff[4])
    else $error("static flash level not followed");
  AST_FLASH_DISABLED:
    assert property ((ce && !csh_ff[2] && $stable(csh_ff))[*3] |-> !flash_out)
    else $error("flash active while disabled");
  AST_RESET_QUIET:
    assert property ($rose(rst_b) |-> !flash_out && !expose && !frame_done)
    else $error("outputs active right after reset");
endmodule : trig_flash_props

bind trigger_flash_sequencer trig_flash_props #(.GPIO_W(GPIO_W)) i_trig_flash_props
(
  .clk(clk), .rst_b(rst_b), .ce(ce), .host_present(host_present), .reg_req(reg_req),
  .rd_data(rd_data), .iso_in(iso_in), .gpio_in(gpio_in), .flash_out(flash_out),
  .rolling_shutter(rolling_shutter), .expose(expose), .frame_done(frame_done)
);

//--- trig_source_flash_unit.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// outside trigger source and flash controller unit
// ----------------------------------------------------------------------
module trig_source_flash_unit
(
  // clock
  input wire logic clk,
  // from the camera
  input wire logic flash_out,
  input wire logic expose,
  // to the camera
  output logic     iso_in
);
  int   n_expose, n_flash, since_exp, expose_width, flash_width, flash_ofs, ecnt, fcnt;
  logic exp_q, fl_q;

  initial
  begin
    iso_in = 1'b0;
    {exp_q, fl_q} = 2'b00;
    {n_expose, n_flash, since_exp, expose_width, flash_width, flash_ofs, ecnt, fcnt} = '0;
  end

  // trigger level changes right after an edge, like a clocked source
  task drive_iso(input logic v);
    @(posedge clk);
    iso_in <= v;
  endtask : drive_iso

  // flash controller side: count pulses, widths and offset from exposure start
  always @(posedge clk)
  begin
    since_exp = (expose && !exp_q) ? 0 : since_exp + 1;
    if (expose && !exp_q)
      n_expose++;
    if (!expose && exp_q)
      expose_width = ecnt;
    ecnt = expose ? ecnt + 1 : 0;
    if (flash_out && !fl_q)
    begin
      n_flash++;
      flash_ofs = since_exp;
    end
    if (!flash_out && fl_q)
      flash_width = fcnt;
    fcnt = flash_out ? fcnt + 1 : 0;
    exp_q = expose;
    fl_q = flash_out;
  end
endmodule : trig_source_flash_unit

//--- trigger_flash_sequencer.sv
`timescale 1ns/1ns
`include "trig_flash_defines.svh"

module trigger_flash_sequencer
#(
  parameter int GPIO_W = 4,
  parameter int CNT_W  = 32
)
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic                         ce,
  // host link state
  input  wire logic                         host_present,
  // register port
  input  wire trig_flash_pkg::reg_req_type  reg_req,
  output logic [31:0]                       rd_data,
  // camera pins
  input  wire logic                         iso_in,
  input  wire logic [GPIO_W-1:0]            gpio_in,
  output logic                              flash_out,
  // sensor side
  input  wire logic                         rolling_shutter,
  output logic                              expose,
  output logic                              frame_done
);

  // ----------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------
  if (GPIO_W < 1 || GPIO_W > 24)
  begin : gen_bad_gpio_w
    $error("GPIO_W must be 1..24");
  end
  if (CNT_W != 32)
  begin : gen_bad_cnt_w
    $error("CNT_W must be 32");
  end

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [`CTRL_WIDTH-1:0]      ctrl_ff;
  logic [31:0]                 trig_delay_ff;
  logic [31:0]                 flash_delay_ff;
  logic [31:0]                 flash_dur_ff;
  logic [31:0]                 exposure_ff;
  logic [31:0]                 latency_ff;
  logic [31:0]                 readout_ff;
  trig_flash_pkg::timing_type  cap_ff;
  trig_flash_pkg::phase_type   phase_ff;
  trig_flash_pkg::phase_type   nxt_phase;
  logic [31:0]                 cnt_ff;
  logic [31:0]                 nxt_cnt;
  logic [31:0]                 fl_cnt_ff;
  logic                        fl_armed_ff;
  logic [7:0]                  tail_ff;
  logic                        flash_ff;
  logic                        nxt_flash;
  logic [31:0]                 rd_data_ff;
  logic [31:0]                 nxt_rd;
  logic                        trig_edge;
  logic                        start;
  logic                        auto_mode;
  logic                        link_lost;
  logic                        wr_en;

  assign link_lost = ~host_present;
  assign wr_en     = ce & reg_req.wr & host_present;

  // does a phase end this cycle (count reached)
  function automatic logic done_at(input logic [31:0] cnt, input logic [31:0] lim);
    done_at = (cnt + 32'h0000_0001 >= lim);
  endfunction : done_at

  // ----------------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------------
  trig_edge_detect i_trig_edge_detect
  (
    .clk        (clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .fall_sel   (ctrl_ff[`CTRL_FALL_EDGE_BIT]),
    .pin        (iso_in),
    .edge_pulse (trig_edge)
  );

  // input is a trigger only in trigger mode
  // gpio never reaches the start logic
  assign start = (phase_ff == trig_flash_pkg::PH_IDLE) & ctrl_ff[`CTRL_RUN_BIT] &
                 (ctrl_ff[`CTRL_TRIG_MODE_BIT]
                  ? (trig_edge | ctrl_ff[`CTRL_SW_TRIG_BIT])
                  : 1'b1);

  assign auto_mode = (cap_ff.flash_delay == 32'h0000_0000) &&
                     (cap_ff.flash_dur == 32'h0000_0000);

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  // host loss clears the output setup
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_ff <= `CTRL_RST;
    else if (ce)
    begin
      if (link_lost)
        ctrl_ff <= `CTRL_RST;
      else if (wr_en && reg_req.addr == `REG_CTRL_OFS)
        ctrl_ff <= reg_req.wdata[`CTRL_WIDTH-1:0];
      else
        ctrl_ff[`CTRL_SW_TRIG_BIT] <= 1'b0;   // software trigger self clears
    end
  end

  // ----------------------------------------------------------------------
  // timing registers
  // ----------------------------------------------------------------------
  // independent programmable times
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trig_delay_ff  <= `TIME_RST;
      flash_delay_ff <= `TIME_RST;
      flash_dur_ff   <= `TIME_RST;
    end
    else if (ce)
    begin
      if (link_lost)
      begin
        trig_delay_ff  <= `TIME_RST;
        flash_delay_ff <= `TIME_RST;
        flash_dur_ff   <= `TIME_RST;
      end
      else if (wr_en)
      begin
        if (reg_req.addr == `REG_TRIG_DELAY_OFS)
          trig_delay_ff <= reg_req.wdata;
        if (reg_req.addr == `REG_FLASH_DELAY_OFS)
          flash_delay_ff <= reg_req.wdata;
        if (reg_req.addr == `REG_FLASH_DUR_OFS)
          flash_dur_ff <= reg_req.wdata;
      end
    end
  end

  // sensor settings: exposure, latency and readout length
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      exposure_ff <= `EXPOSURE_RST;
      latency_ff  <= `LATENCY_RST;
      readout_ff  <= `READOUT_RST;
    end
    else if (wr_en)
    begin
      if (reg_req.addr == `REG_EXPOSURE_OFS)
        exposure_ff <= reg_req.wdata;
      if (reg_req.addr == `REG_LATENCY_OFS)
        latency_ff <= reg_req.wdata;
      if (reg_req.addr == `REG_READOUT_OFS)
        readout_ff <= reg_req.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // capture snapshot
  // ----------------------------------------------------------------------
  // values written while idle take effect at the next start
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cap_ff <= '0;
    else if (ce && start)
    begin
      cap_ff.trig_delay  <= ctrl_ff[`CTRL_TRIG_MODE_BIT] ? trig_delay_ff : 32'h0000_0000;
      cap_ff.flash_delay <= flash_delay_ff;
      cap_ff.flash_dur   <= flash_dur_ff;
      cap_ff.exposure    <= exposure_ff;
      cap_ff.latency     <= latency_ff;
      cap_ff.readout     <= readout_ff;
    end
  end

  // ----------------------------------------------------------------------
  // sequence next state
  // ----------------------------------------------------------------------
  // delay, latency, exposure, readout
  // latency is a fixed count from the snapshot
  always_comb
  begin
    nxt_phase = phase_ff;
    nxt_cnt   = cnt_ff + 32'h0000_0001;
    case (phase_ff)
      trig_flash_pkg::PH_IDLE:
      begin
        nxt_cnt = 32'h0000_0000;
        if (start)
          nxt_phase = trig_flash_pkg::PH_TRIG_DELAY;
      end
      trig_flash_pkg::PH_TRIG_DELAY:
        if (cnt_ff >= cap_ff.trig_delay)
        begin
          nxt_phase = trig_flash_pkg::PH_LATENCY;
          nxt_cnt   = 32'h0000_0000;
        end
      trig_flash_pkg::PH_LATENCY:
        if (cnt_ff >= cap_ff.latency)
        begin
          nxt_phase = trig_flash_pkg::PH_EXPOSE;
          nxt_cnt   = 32'h0000_0000;
        end
      trig_flash_pkg::PH_EXPOSE:
        if (done_at(cnt_ff, cap_ff.exposure))
        begin
          nxt_phase = trig_flash_pkg::PH_READOUT;
          nxt_cnt   = 32'h0000_0000;
        end
      trig_flash_pkg::PH_READOUT:
        if (done_at(cnt_ff, cap_ff.readout))
        begin
          nxt_phase = trig_flash_pkg::PH_IDLE;
          nxt_cnt   = 32'h0000_0000;
        end
      default:
      begin
        nxt_phase = trig_flash_pkg::PH_IDLE;
        nxt_cnt   = 32'h0000_0000;
      end
    endcase
  end

  // sequence registers; host loss aborts any capture in flight
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_ff <= trig_flash_pkg::PH_IDLE;
      cnt_ff   <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (link_lost)
      begin
        phase_ff <= trig_flash_pkg::PH_IDLE;
        cnt_ff   <= 32'h0000_0000;
      end
      else
      begin
        phase_ff <= nxt_phase;
        cnt_ff   <= nxt_cnt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // flash timing
  // ----------------------------------------------------------------------
  // manual flash counter runs from exposure start
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fl_cnt_ff   <= 32'h0000_0000;
      fl_armed_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (start || link_lost)
      begin
        fl_cnt_ff   <= 32'h0000_0000;
        fl_armed_ff <= 1'b0;
      end
      else if (phase_ff == trig_flash_pkg::PH_LATENCY && nxt_phase == trig_flash_pkg::PH_EXPOSE)
      begin
        fl_cnt_ff   <= 32'h0000_0000;
        fl_armed_ff <= 1'b1;
      end
      else if (fl_armed_ff)
        fl_cnt_ff <= fl_cnt_ff + 32'h0000_0001;
    end
  end

  // auto flash tail after exposure, longer for rolling shutter
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tail_ff <= 8'h00;
    else if (ce)
    begin
      if (start || link_lost)
        tail_ff <= 8'h00;
      else if (phase_ff == trig_flash_pkg::PH_EXPOSE && nxt_phase == trig_flash_pkg::PH_READOUT)
        tail_ff <= rolling_shutter ? 8'(`AUTO_TAIL_CYC + `ROLLING_EXTRA_CYC)
                                   : 8'(`AUTO_TAIL_CYC);
      else if (tail_ff != 8'h00)
        tail_ff <= tail_ff - 8'h01;
    end
  end

  // flash level choice
  always_comb
  begin
    nxt_flash = 1'b0;
    if (!ctrl_ff[`CTRL_FLASH_EN_BIT])
      nxt_flash = 1'b0;
    else if (ctrl_ff[`CTRL_FLASH_STAT_BIT])
      nxt_flash = ctrl_ff[`CTRL_STAT_LEVEL_BIT];
    else if (start)
      nxt_flash = 1'b0;
    // same in free run, so on for each exposure and its tail
    else if (auto_mode)
      nxt_flash = (nxt_phase == trig_flash_pkg::PH_EXPOSE) || (tail_ff > 8'h01) ||
                  (phase_ff == trig_flash_pkg::PH_EXPOSE && nxt_phase != trig_flash_pkg::PH_EXPOSE);
    // manual window of delay then duration
    else if (fl_armed_ff || nxt_phase == trig_flash_pkg::PH_EXPOSE)
      nxt_flash = (fl_armed_ff ? fl_cnt_ff + 32'h0000_0001 : 32'h0000_0000) >= cap_ff.flash_delay &&
                  (fl_armed_ff ? fl_cnt_ff + 32'h0000_0001 : 32'h0000_0000) <
                  cap_ff.flash_delay + cap_ff.flash_dur;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      flash_ff <= 1'b0;
    else if (ce)
      flash_ff <= link_lost ? 1'b0 : nxt_flash;
  end

  assign flash_out  = flash_ff;
  assign expose     = (phase_ff == trig_flash_pkg::PH_EXPOSE);
  assign frame_done = ce & (phase_ff == trig_flash_pkg::PH_READOUT) &
                      (nxt_phase == trig_flash_pkg::PH_IDLE) & ~link_lost;

  // ----------------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------------
  // isolated input level readable; gpio readable
  always_comb
  begin
    nxt_rd = 32'h0000_0000;
    case (reg_req.addr)
      `REG_CTRL_OFS:        nxt_rd = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_ff};
      `REG_TRIG_DELAY_OFS:  nxt_rd = trig_delay_ff;
      `REG_FLASH_DELAY_OFS: nxt_rd = flash_delay_ff;
      `REG_FLASH_DUR_OFS:   nxt_rd = flash_dur_ff;
      `REG_EXPOSURE_OFS:    nxt_rd = exposure_ff;
      `REG_LATENCY_OFS:     nxt_rd = latency_ff;
      `REG_READOUT_OFS:     nxt_rd = readout_ff;
      `REG_STATUS_OFS:
      begin
        nxt_rd[`STAT_BUSY_BIT]                   = (phase_ff != trig_flash_pkg::PH_IDLE);
        nxt_rd[`STAT_FLASH_BIT]                  = flash_ff;
        nxt_rd[`STAT_ISO_IN_BIT]                 = iso_in;
        nxt_rd[`STAT_PHASE_LSB +: 3]             = phase_ff;
        nxt_rd[`STAT_GPIO_LSB +: GPIO_W]         = gpio_in;
      end
      default:              nxt_rd = 32'h0000_0000;  // unmapped reads zero
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data_ff <= 32'h0000_0000;
    else if (ce)
      rd_data_ff <= reg_req.rd ? nxt_rd : 32'h0000_0000;
  end

  assign rd_data = rd_data_ff;

endmodule : trigger_flash_sequencer

//--- trigger_flash_sequencer_tb_top.sv
`timescale 1ns/1ns
`include "trig_flash_defines.svh"
module trigger_flash_sequencer_tb_top;
  logic                        clk, rst_b, ce, host_present, rolling_shutter;
  logic                        iso_in, flash_out, expose, frame_done;
  logic [3:0]                  gpio_in;
  logic [31:0]                 rd_data, v;
  trig_flash_pkg::reg_req_type reg_req;
  int                          n_mismatch, n_tests, c0, c1, n0, n_done;

  trigger_flash_sequencer #(.GPIO_W(4), .CNT_W(32)) i_trigger_flash_sequencer
  (
    .clk(clk), .rst_b(rst_b), .ce(ce), .host_present(host_present), .reg_req(reg_req),
    .rd_data(rd_data), .iso_in(iso_in), .gpio_in(gpio_in), .flash_out(flash_out),
    .rolling_shutter(rolling_shutter), .expose(expose), .frame_done(frame_done)
  );
  trig_source_flash_unit i_trig_source_flash_unit
  (
    .clk(clk), .flash_out(flash_out), .expose(expose), .iso_in(iso_in)
  );
  // completed frames, counted from the one-cycle pulse before it drops
  always @(posedge clk)
    if (frame_done === 1'b1)
      n_done++;

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task report_and_stop;
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 v = rd_data;
    check(v, exp);
  endtask : rd
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task wait_expose(output int c);
    c = 0;
    while (expose !== 1'b1 && c < 300)
    begin
      @(posedge clk);
      #1 c++;
    end
  endtask : wait_expose

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    logic [31:0] tab [0:8];
    tab = '{0, 0, 0, 0, `EXPOSURE_RST, `LATENCY_RST, `READOUT_RST, 0, 0};
    for (int i = 0; i < 9; i++)
      if (i != 7) rd(4'(i), tab[i]);
    check(flash_out, 0);
  endtask : t_reset
  task t_edges;
    n0 = i_trig_source_flash_unit.n_expose;
    wr(`REG_CTRL_OFS, 32'h25);
    i_trig_source_flash_unit.drive_iso(1'b1);
    tick(40);
    check(i_trig_source_flash_unit.n_expose - n0, 1);
    check(i_trig_source_flash_unit.expose_width, 5);
    i_trig_source_flash_unit.drive_iso(1'b0);
    tick(40);
    check(i_trig_source_flash_unit.n_expose - n0, 1);
    // second rising edge lands inside the exposure of the first
    i_trig_source_flash_unit.drive_iso(1'b1);
    tick(4);
    i_trig_source_flash_unit.drive_iso(1'b0);
    tick(1);
    i_trig_source_flash_unit.drive_iso(1'b1);
    tick(40);
    check(i_trig_source_flash_unit.n_expose - n0, 2);
    @(posedge clk) gpio_in <= 4'hA;
    tick(40);
    check(i_trig_source_flash_unit.n_expose - n0, 2);
    rd(`REG_STATUS_OFS, 32'h0000_0A04);
    wr(`REG_CTRL_OFS, 32'h27);
    i_trig_source_flash_unit.drive_iso(1'b0);
    tick(40);
    check(i_trig_source_flash_unit.n_expose - n0, 3);
  endtask : t_edges
  task t_delay;
    wr(`REG_CTRL_OFS, 32'h61);
    wait_expose(c0);
    tick(30);
    wr(`REG_TRIG_DELAY_OFS, 32'd20);
    wr(`REG_CTRL_OFS, 32'h61);
    wait_expose(c1);
    tick(30);
    check(c1 - c0, 20);
  endtask : t_delay
  task t_flash;
    wr(`REG_TRIG_DELAY_OFS, 32'h0);
    wr(`REG_CTRL_OFS, 32'h65);
    tick(40);
    c0 = i_trig_source_flash_unit.flash_width;
    check(c0, 5 + `AUTO_TAIL_CYC);
    @(posedge clk) rolling_shutter <= 1'b1;
    wr(`REG_CTRL_OFS, 32'h65);
    tick(40);
    check(i_trig_source_flash_unit.flash_width - c0, `ROLLING_EXTRA_CYC);
    @(posedge clk) rolling_shutter <= 1'b0;
    wr(`REG_FLASH_DELAY_OFS, 32'd3);
    wr(`REG_FLASH_DUR_OFS, 32'd2);
    wr(`REG_CTRL_OFS, 32'h65);
    tick(40);
    check(i_trig_source_flash_unit.flash_width, 2);
    check(i_trig_source_flash_unit.flash_ofs, 3);
  endtask : t_flash
  task t_free;
    // manual timing for free run, with a duration far past one frame
    wr(`REG_FLASH_DELAY_OFS, 32'h0);
    wr(`REG_FLASH_DUR_OFS, 32'd1000);
    n0 = i_trig_source_flash_unit.n_flash;
    wr(`REG_CTRL_OFS, 32'h24);
    tick(60);
    check(i_trig_source_flash_unit.n_flash - n0 >= 2, 1);
    check(i_trig_source_flash_unit.flash_width < 1000, 1);
    wr(`REG_FLASH_DUR_OFS, 32'h0);
    n0 = i_trig_source_flash_unit.n_expose;
    tick(60);
    check(i_trig_source_flash_unit.n_expose - n0 >= 3, 1);
    check(i_trig_source_flash_unit.flash_width, 5 + `AUTO_TAIL_CYC);
    wr(`REG_CTRL_OFS, 32'h04);
    tick(40);
  endtask : t_free
  task t_static_host;
    wr(`REG_CTRL_OFS, 32'h1C);
    tick(3);
    check(flash_out, 1);
    wr(`REG_TRIG_DELAY_OFS, 32'd7);
    host_present <= 1'b0;
    tick(3);
    check(flash_out, 0);
    wr(`REG_CTRL_OFS, 32'h1C);
    host_present <= 1'b1;
    tick(2);
    rd(`REG_CTRL_OFS, 32'h0);
    rd(`REG_TRIG_DELAY_OFS, 32'h0);
    rd(`REG_EXPOSURE_OFS, 32'd5);
    check(flash_out, 0);
  endtask : t_static_host
  // clock enable low mid exposure: sequence and register writes freeze
  task t_freeze;
    n0 = n_done;
    wr(`REG_CTRL_OFS, 32'h61);
    wait_expose(c0);
    @(posedge clk) ce <= 1'b0;
    wr(`REG_TRIG_DELAY_OFS, 32'd9);
    tick(20);
    check(expose, 1);
    @(posedge clk) ce <= 1'b1;
    tick(20);
    check(expose, 0);
    check(n_done - n0, 1);
    rd(`REG_TRIG_DELAY_OFS, 32'h0);
  endtask : t_freeze

  // ----------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // the whole run needs about 720 cycles; over 25 times that means a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    host_present = 1'b1;
    rolling_shutter = 1'b0;
    gpio_in = 4'h0;
    reg_req = '0;
    {n_mismatch, n_tests} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    wr(`REG_EXPOSURE_OFS, 32'd5);
    wr(`REG_LATENCY_OFS, 32'd2);
    wr(`REG_READOUT_OFS, 32'd6);
    t_edges();
    t_delay();
    t_flash();
    t_free();
    t_static_host();
    t_freeze();
    report_and_stop();
  end
endmodule : trigger_flash_sequencer_tb_top
